// ---- core/vectored_irq_command_status_regs.sv ----
// command and status registers of a 32-source vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none

module vectored_irq_command_status_regs
  import irq_ctrl_pkg::*;
#(
  parameter int unsigned NUM_SRC = 32
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [NUM_SRC-1:0] src_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   core_fast_request_line_n,
  output logic                   core_normal_request_line_n,
  output logic                   irq
);

  // the bit map has room for 32 sources and needs the fast and system slots
  if (NUM_SRC < 2 || NUM_SRC > 32) begin : g_bad_num_src
    $error("NUM_SRC must lie between 2 and 32");
  end

  localparam logic [31:0] SRC_USED = 32'((64'h1 << NUM_SRC) - 64'h1);

  // byte enables widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // lowest set bit wins; bit 0 is excluded by the caller
  function automatic logic [4:0] first_set(input logic [31:0] v);
    first_set = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  // every address that answers OKAY
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a[1:0] == 2'h0) &&
                ((a >= OFF_VEC_BASE && a < OFF_NVEC) ||
                 (a >= OFF_NVEC && a <= OFF_LINE) ||
                 (a >= OFF_EN && a <= OFF_EVT_MASK));
  endfunction

  // bus slave state
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       wd_q;
  logic [3:0]        ws_q;
  logic              aw_full_q;
  logic              w_full_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // controller state
  logic [31:0]       mask_q;
  logic [31:0]       pend_q;
  logic [31:0]       src_prev_q;
  logic [31:0]       spur_q;
  logic [31:0]       vec_q [32];
  debug_ctrl_t       dbg_q;
  logic              cur_valid_q;
  logic [4:0]        cur_id_q;
  logic              fast_n_q;
  logic              norm_n_q;
  event_t            evt_q;
  event_t            evt_mask_q;
  logic              irq_q;

  // handshakes of the three request channels
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take  = s_axi_wvalid & wready_q;
  wire ar_take = s_axi_arvalid & arready_q;
  wire do_wr   = aw_full_q & w_full_q & ~bvalid_q;

  wire aw_full_d = do_wr ? 1'b0 : (aw_full_q | aw_take);
  wire w_full_d  = do_wr ? 1'b0 : (w_full_q | w_take);
  wire rvalid_d  = ar_take ? 1'b1 : (rvalid_q & ~s_axi_rready);

  // write decode; unwritten byte lanes carry zeros into commands
  wire [31:0] wmask   = strb_mask(ws_q);
  wire [31:0] cmd_val = wd_q & wmask & SRC_USED;
  wire wr_en   = do_wr & (aw_addr_q == OFF_EN);
  wire wr_dis  = do_wr & (aw_addr_q == OFF_DIS);
  wire wr_clr  = do_wr & (aw_addr_q == OFF_CLR);
  wire wr_set  = do_wr & (aw_addr_q == OFF_SET);
  wire wr_done = do_wr & (aw_addr_q == OFF_DONE);
  wire wr_spur = do_wr & (aw_addr_q == OFF_SPUR);
  wire wr_dbg  = do_wr & (aw_addr_q == OFF_DBG);
  wire wr_emsk = do_wr & (aw_addr_q == OFF_EVT_MASK);
  wire wr_vec  = do_wr & (aw_addr_q[8:7] == 2'b01) & (aw_addr_q[1:0] == 2'h0);
  wire [4:0] wr_vec_idx = aw_addr_q[6:2];

  // read decode
  wire rd_nvec = ar_take & (s_axi_araddr == OFF_NVEC);
  wire rd_fvec = ar_take & (s_axi_araddr == OFF_FVEC);
  wire rd_evt  = ar_take & (s_axi_araddr == OFF_EVT_STAT);

  // candidates for the two core lines
  wire [31:0] active    = pend_q & mask_q;
  wire        fast_cand = active[FAST_SRC];
  wire [31:0] norm_set  = active & ~(32'h0000_0001 << FAST_SRC);
  wire        norm_cand = |norm_set;
  wire [4:0]  norm_id   = first_set(norm_set);

  // vector values offered on the two vector reads
  wire [31:0] nvec_val = norm_cand ? vec_q[norm_id] : spur_q;
  wire [31:0] fvec_val = fast_cand ? vec_q[FAST_SRC] : spur_q;

  // acknowledge moves from read to write of the vector address in protection mode,
  // so a debugger can look at the vector without taking the interrupt
  wire protect = dbg_q.protection_mode_bit;
  wire nvec_ack = protect ? (do_wr & (aw_addr_q == OFF_NVEC)) : rd_nvec;
  wire fvec_ack = protect ? (do_wr & (aw_addr_q == OFF_FVEC)) : rd_fvec;

  // pending clears caused by acknowledges; edge requests are consumed when taken
  wire [31:0] ack_clr = ((nvec_ack & norm_cand) ? (32'h0000_0001 << norm_id) : ZERO32) |
                        ((fvec_ack & fast_cand) ? (32'h0000_0001 << FAST_SRC) : ZERO32);

  // source rising edges are the hardware set events
  wire [31:0] src_now  = 32'(src_in) & SRC_USED;
  wire [31:0] src_rise = src_now & ~src_prev_q;

  // next mask and pending; a set in the same cycle beats any clear
  wire [31:0] en_bits  = wr_en ? cmd_val : ZERO32;
  wire [31:0] dis_bits = wr_dis ? cmd_val : ZERO32;
  wire [31:0] clr_bits = wr_clr ? cmd_val : ZERO32;
  wire [31:0] set_bits = wr_set ? cmd_val : ZERO32;
  wire [31:0] mask_d   = (mask_q | en_bits) & ~dis_bits;
  wire [31:0] pend_d   = (pend_q & ~clr_bits & ~ack_clr) | set_bits | src_rise;

  // core request lines, active low; the global mask overrides everything
  wire gmask     = dbg_q.global_line_mask_bit;
  wire fast_on   = fast_cand & ~gmask;
  wire norm_on   = norm_cand & ~cur_valid_q & ~gmask;

  // block events and their read-to-clear
  event_t evt_new;
  assign evt_new.spurious_norm = nvec_ack & ~norm_cand;
  assign evt_new.spurious_fast = fvec_ack & ~fast_cand;
  assign evt_new.service_done  = wr_done;
  wire [2:0] evt_d = (evt_q & ~{3{rd_evt}}) | evt_new;

  // read multiplexer
  wire [31:0] rd_val =
    (s_axi_araddr[8:7] == 2'b01)        ? vec_q[s_axi_araddr[6:2]] :
    (s_axi_araddr == OFF_NVEC)          ? nvec_val :
    (s_axi_araddr == OFF_FVEC)          ? fvec_val :
    (s_axi_araddr == OFF_CUR_ID)        ? {27'h0000000, cur_id_q} :
    (s_axi_araddr == OFF_PEND)          ? pend_q :
    (s_axi_araddr == OFF_MASK)          ? mask_q :
    (s_axi_araddr == OFF_LINE)          ? {30'h00000000, ~norm_n_q, ~fast_n_q} :
    (s_axi_araddr == OFF_SPUR)          ? spur_q :
    (s_axi_araddr == OFF_DBG)           ? {30'h00000000, dbg_q} :
    (s_axi_araddr == OFF_EVT_STAT)      ? {29'h00000000, evt_q} :
    (s_axi_araddr == OFF_EVT_MASK)      ? {29'h00000000, evt_mask_q} : ZERO32;

  // write address and data holding; taken in either order
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_addr_q <= '0;
      wd_q      <= ZERO32;
      ws_q      <= 4'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q  <= ~w_full_d;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end

  // write response; it is raised on the same edge as the register update
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OK;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(aw_addr_q) ? RESP_OK : RESP_ER;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel; data is captured at the address handshake
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= ZERO32;
      rresp_q   <= RESP_OK;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_val;
        rresp_q <= is_mapped(s_axi_araddr) ? RESP_OK : RESP_ER;
      end
    end
  end

  // mask, pending and source history
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_q     <= ZERO32;
      pend_q     <= ZERO32;
      src_prev_q <= ZERO32;
    end else begin
      mask_q     <= mask_d;
      pend_q     <= pend_d;
      src_prev_q <= src_now;
    end
  end

  // software-owned configuration; byte lanes merge into the old value
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spur_q     <= ZERO32;
      dbg_q      <= '0;
      evt_mask_q <= '0;
    end else begin
      if (wr_spur) begin
        spur_q <= (spur_q & ~wmask) | (wd_q & wmask);
      end
      if (wr_dbg & ws_q[0]) begin
        dbg_q <= wd_q[1:0];
      end
      if (wr_emsk & ws_q[0]) begin
        evt_mask_q <= wd_q[2:0];
      end
    end
  end

  // handler vector table, one word per source
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        vec_q[i] <= ZERO32;
      end
    end else if (wr_vec) begin
      vec_q[wr_vec_idx] <= (vec_q[wr_vec_idx] & ~wmask) | (wd_q & wmask);
    end
  end

  // current interrupt: taken on a normal acknowledge, released by the done write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_valid_q <= 1'b0;
      cur_id_q    <= 5'h00;
    end else if (nvec_ack & norm_cand) begin
      cur_valid_q <= 1'b1;
      cur_id_q    <= norm_id;
    end else if (wr_done) begin
      cur_valid_q <= 1'b0;
    end
  end

  // core lines and interrupt output, all from flops
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fast_n_q <= 1'b1;
      norm_n_q <= 1'b1;
      evt_q    <= '0;
      irq_q    <= 1'b0;
    end else begin
      fast_n_q <= ~fast_on;
      norm_n_q <= ~norm_on;
      evt_q    <= evt_d;
      irq_q    <= |(evt_q & evt_mask_q);
    end
  end

  assign s_axi_awready              = awready_q;
  assign s_axi_wready               = wready_q;
  assign s_axi_bvalid               = bvalid_q;
  assign s_axi_bresp                = bresp_q;
  assign s_axi_arready              = arready_q;
  assign s_axi_rvalid               = rvalid_q;
  assign s_axi_rdata                = rdata_q;
  assign s_axi_rresp                = rresp_q;
  assign core_fast_request_line_n   = fast_n_q;
  assign core_normal_request_line_n = norm_n_q;
  assign irq                        = irq_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // mask register read back
  a_mask_read_back: assert property (
    ar_take && s_axi_araddr == OFF_MASK |=> rdata_q == $past(mask_q))
    else $error("mask status read does not match the mask");

  // enable and disable commands
  a_enable_sets_mask: assert property (
    wr_en |=> ((mask_q & $past(cmd_val)) == $past(cmd_val)) &&
              ((mask_q & ~$past(cmd_val)) == ($past(mask_q) & ~$past(cmd_val))))
    else $error("enable command did not set exactly the written bits");

  a_disable_clears_mask: assert property (
    wr_dis |=> ((mask_q & $past(cmd_val)) == ZERO32) &&
               ((mask_q & ~$past(cmd_val)) == ($past(mask_q) & ~$past(cmd_val))))
    else $error("disable command did not clear exactly the written bits");

  // pending set and clear commands
  a_pending_set_cmd: assert property (
    wr_set |=> (pend_q & $past(cmd_val)) == $past(cmd_val))
    else $error("set command left a written bit not pending");

  a_pending_clear_cmd: assert property (
    wr_clr |=> (pend_q & $past(cmd_val) & ~$past(src_rise)) == ZERO32)
    else $error("clear command left a written bit pending");

  // service done ends the current interrupt whatever the data
  a_done_ends_current: assert property (
    wr_done && !(nvec_ack && norm_cand) |=> !cur_valid_q)
    else $error("service done write did not end the current interrupt");

  // spurious vector written value is kept
  a_spurious_write: assert property (
    wr_spur && ws_q == 4'hF |=> spur_q == $past(wd_q))
    else $error("spurious vector register lost a full word write");

  // spurious acknowledge returns the spurious value
  a_spurious_vec_read: assert property (
    ar_take && s_axi_araddr == OFF_NVEC && !norm_cand |=> rdata_q == $past(spur_q))
    else $error("spurious normal read did not return the spurious vector");

  // global mask keeps both lines quiet two edges later and onward
  a_global_mask_lines: assert property (
    dbg_q.global_line_mask_bit [*2] |-> fast_n_q && norm_n_q)
    else $error("request line active while globally masked");

  a_fast_line_follow: assert property (
    !gmask && fast_cand |=> !core_fast_request_line_n)
    else $error("fast line not driven for an enabled pending fast source");

  // protection mode read leaves the current interrupt and pending as they were
  a_protect_read_quiet: assert property (
    protect && rd_nvec && !do_wr && !wr_clr |=>
      cur_valid_q == $past(cur_valid_q) && cur_id_q == $past(cur_id_q) &&
      (pend_q & $past(pend_q)) == $past(pend_q))
    else $error("protected vector read changed controller state");

endmodule

`default_nettype wire

// ---- core/irq_ctrl_pkg.sv ----
// constants, field layouts and carrier types of the vectored interrupt command block
// Contract
// - mask status bit reads 1 for an enabled source, 0 for a disabled one
// - bit 0 fast source, bit 1 system source, bit n peripheral source n
// - core line status: bit 0 fast line active, bit 1 normal line active
// - enable command sets the mask for every bit written 1, others untouched
// - disable command clears the mask for every bit written 1, others untouched
// - clear command drops pending for every bit written 1, zeros do nothing
// - set command makes pending every bit written 1, zeros do nothing
// - any write to the service done location ends the current interrupt
// - spurious vector is a 32-bit read/write register that resets to zero
// - spurious normal or fast acknowledge returns the spurious vector value
// - debug bit 0 selects protection mode, register resets to zero
// - debug bit 1 high forces both core request lines inactive
// - debug bit 1 low lets both lines follow the normal request logic
// - normal vector read returns the current source vector, else the spurious one; the code returns the lowest-numbered enabled pending non-fast source vector
// - pending status bit reads 1 while the matching source is pending
package irq_ctrl_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 32;

  // byte offsets of the register map
  localparam logic [ADDR_W-1:0] OFF_VEC_BASE = 9'h080;
  localparam logic [ADDR_W-1:0] OFF_NVEC     = 9'h100;
  localparam logic [ADDR_W-1:0] OFF_FVEC     = 9'h104;
  localparam logic [ADDR_W-1:0] OFF_CUR_ID   = 9'h108;
  localparam logic [ADDR_W-1:0] OFF_PEND     = 9'h10C;
  localparam logic [ADDR_W-1:0] OFF_MASK     = 9'h110;
  localparam logic [ADDR_W-1:0] OFF_LINE     = 9'h114;
  localparam logic [ADDR_W-1:0] OFF_EN       = 9'h120;
  localparam logic [ADDR_W-1:0] OFF_DIS      = 9'h124;
  localparam logic [ADDR_W-1:0] OFF_CLR      = 9'h128;
  localparam logic [ADDR_W-1:0] OFF_SET      = 9'h12C;
  localparam logic [ADDR_W-1:0] OFF_DONE     = 9'h130;
  localparam logic [ADDR_W-1:0] OFF_SPUR     = 9'h134;
  localparam logic [ADDR_W-1:0] OFF_DBG      = 9'h138;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT = 9'h140;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 9'h144;

  // per-source bit map
  localparam int unsigned FAST_SRC = 0;
  localparam int unsigned SYS_SRC  = 1;

  localparam logic [31:0] ZERO32  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OK = 2'h0;
  localparam logic [1:0]  RESP_ER = 2'h2;

  // debug control word, low bits of the register
  typedef struct packed {
    logic global_line_mask_bit;
    logic protection_mode_bit;
  } debug_ctrl_t;

  // sticky block events, low bits of the event status register
  typedef struct packed {
    logic service_done;
    logic spurious_fast;
    logic spurious_norm;
  } event_t;

endpackage

// ---- verification/core_model.sv ----
// behavioural model of the processor core inputs fed by the request lines
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic core_fast_request_line_n,
  input  wire logic core_normal_request_line_n,
  output logic      fast_active,
  output logic      normal_active
);
  // the core samples its request pins once a clock; low means asserted
  // a reset core ignores the pins, so both flags start clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fast_active   <= 1'b0;
      normal_active <= 1'b0;
    end else begin
      fast_active   <= ~core_fast_request_line_n;
      normal_active <= ~core_normal_request_line_n;
    end
  end
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench of the interrupt command and status registers
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import irq_ctrl_pkg::*;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [31:0]       src_in  = 32'h0000_0000;
  logic [ADDR_W-1:0] awaddr  = 9'h000;
  logic              awvalid = 1'b0;
  logic [31:0]       wdata   = 32'h0000_0000;
  logic [3:0]        wstrb   = 4'hF;
  logic              wvalid  = 1'b0;
  logic              bready  = 1'b0;
  logic [ADDR_W-1:0] araddr  = 9'h000;
  logic              arvalid = 1'b0;
  logic              rready  = 1'b0;
  wire logic         awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  wire logic         fast_n, normal_n, irq, fast_active, normal_active;
  int                errors  = 0;
  int                n_tests = 0;
  logic [31:0]       seed    = 32'h0000_0014;
  logic [31:0]       m, p, v, sv;
  logic [31:0]       d;
  logic [1:0]        r;

  vectored_irq_command_status_regs #(.NUM_SRC(32)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .src_in(src_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_fast_request_line_n(fast_n), .core_normal_request_line_n(normal_n),
    .irq(irq)
  );

  core_model u_core (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .core_fast_request_line_n(fast_n), .core_normal_request_line_n(normal_n),
    .fast_active(fast_active), .normal_active(normal_active)
  );

  // 40 MHz system clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // set/clear command effect on a per-source word
  function automatic logic [31:0] upd(input logic [31:0] cur, input logic [31:0] val,
                                      input logic on);
    return on ? (cur | val) : (cur & ~val);
  endfunction

  task automatic tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic ran_out;
    errors++;
    $display("MISMATCH at %0t: bus wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // outputs read right after an edge still hold the values sampled at it
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat,
                        output logic [1:0] resp);
    logic done;
    int   n;
    @(posedge sys_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= dat;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    done = 1'b0;
    resp = 2'h3;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) ran_out();
  endtask

  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] dat,
                        output logic [1:0] resp);
    logic done;
    int   n;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    done = 1'b0;
    dat = 32'h0000_0000;
    resp = 2'h3;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) ran_out();
  endtask

  task automatic wr_ok(input logic [ADDR_W-1:0] a, input logic [31:0] dat);
    logic [1:0] resp;
    bus_wr(a, dat, resp);
    chk_resp(resp, RESP_OK);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] dat;
    logic [1:0]  resp;
    bus_rd(a, dat, resp);
    chk_resp(resp, RESP_OK);
    chk_data(dat, exp);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    // reset contents, write-only places read back zero
    rd_chk(OFF_MASK, ZERO32);
    rd_chk(OFF_SPUR, ZERO32);
    rd_chk(OFF_DBG, ZERO32);
    rd_chk(OFF_LINE, ZERO32);
    rd_chk(OFF_PEND, ZERO32);
    rd_chk(OFF_EN, ZERO32);
    $display("test reset done");
    // random enable and disable words against a running model
    m = ZERO32;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr_ok(OFF_EN, seed);
      m = upd(m, seed, 1'b1);
      seed = lfsr(seed);
      wr_ok(OFF_DIS, seed);
      m = upd(m, seed, 1'b0);
      rd_chk(OFF_MASK, m);
    end
    wr_ok(OFF_EN, ZERO32);
    rd_chk(OFF_MASK, m);
    wr_ok(OFF_MASK, 32'hFFFF_FFFF);
    rd_chk(OFF_MASK, m);
    wr_ok(OFF_DIS, 32'hFFFF_FFFF);
    rd_chk(OFF_MASK, ZERO32);
    // only the strobed byte lane carries command bits
    wstrb <= 4'h2;
    wr_ok(OFF_EN, 32'hFFFF_FFFF);
    rd_chk(OFF_MASK, upd(ZERO32, 32'h0000_FF00, 1'b1));
    wstrb <= 4'hF;
    wr_ok(OFF_DIS, 32'hFFFF_FFFF);
    rd_chk(OFF_MASK, ZERO32);
    $display("test mask done");
    // pending set and clear, all sources disabled so nothing is acknowledged
    p = ZERO32;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr_ok(OFF_SET, seed);
      p = upd(p, seed, 1'b1);
      rd_chk(OFF_PEND, p);
      seed = lfsr(seed);
      wr_ok(OFF_CLR, seed);
      p = upd(p, seed, 1'b0);
      rd_chk(OFF_PEND, p);
    end
    wr_ok(OFF_CLR, 32'hFFFF_FFFF);
    rd_chk(OFF_PEND, ZERO32);
    // a source edge makes that source pending
    @(posedge sys_clk);
    src_in <= 32'h0000_0008;
    repeat (2) @(posedge sys_clk);
    src_in <= 32'h0000_0000;
    rd_chk(OFF_PEND, 32'h0000_0008);
    wr_ok(OFF_CLR, 32'hFFFF_FFFF);
    $display("test pending done");
    // fast line, general mask forcing it off and back
    wr_ok(OFF_EN, 32'h0000_0081);
    wr_ok(OFF_SET, 32'h0000_0001);
    rd_chk(OFF_LINE, 32'h0000_0001);
    chk_bit(fast_active, 1'b1);
    wr_ok(OFF_DBG, 32'h0000_0002);
    rd_chk(OFF_LINE, ZERO32);
    chk_bit(fast_active, 1'b0);
    wr_ok(OFF_DBG, ZERO32);
    rd_chk(OFF_LINE, 32'h0000_0001);
    // a real fast acknowledge returns the vector of source 0 and takes it
    wr_ok(OFF_VEC_BASE, 32'h0000_0F00);
    rd_chk(OFF_FVEC, 32'h0000_0F00);
    wr_ok(OFF_CLR, 32'h0000_0001);
    rd_chk(OFF_LINE, ZERO32);
    // normal line, vector fetch and end of service
    seed = lfsr(seed);
    v = seed;
    wr_ok(OFF_VEC_BASE + 9'h01C, v);
    seed = lfsr(seed);
    sv = seed;
    wr_ok(OFF_SPUR, sv);
    rd_chk(OFF_SPUR, sv);
    wr_ok(OFF_SET, 32'h0000_0080);
    rd_chk(OFF_LINE, 32'h0000_0002);
    chk_bit(normal_active, 1'b1);
    rd_chk(OFF_NVEC, v);
    rd_chk(OFF_PEND, ZERO32);
    rd_chk(OFF_LINE, ZERO32);
    seed = lfsr(seed);
    wr_ok(OFF_DONE, seed);
    rd_chk(OFF_NVEC, sv);
    rd_chk(OFF_FVEC, sv);
    $display("test vectors done");
    // block events stay hidden until their mask is set, a read clears them
    chk_bit(irq, 1'b0);
    wr_ok(OFF_EVT_MASK, 32'h0000_0007);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq, 1'b1);
    rd_chk(OFF_EVT_STAT, 32'h0000_0007);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq, 1'b0);
    rd_chk(OFF_EVT_STAT, ZERO32);
    $display("test events done");
    // protection mode: the vector read must leave the pending bit alone
    wr_ok(OFF_DBG, 32'h0000_0001);
    rd_chk(OFF_DBG, 32'h0000_0001);
    seed = lfsr(seed);
    v = seed;
    wr_ok(OFF_VEC_BASE + 9'h024, v);
    wr_ok(OFF_EN, 32'h0000_0200);
    wr_ok(OFF_SET, 32'h0000_0200);
    rd_chk(OFF_NVEC, v);
    rd_chk(OFF_PEND, 32'h0000_0200);
    // in protection mode the acknowledge is a write to the vector place
    wr_ok(OFF_NVEC, seed);
    rd_chk(OFF_PEND, ZERO32);
    rd_chk(OFF_CUR_ID, 32'h0000_0009);
    wr_ok(OFF_DONE, seed);
    wr_ok(OFF_DBG, ZERO32);
    $display("test protection done");
    // unmapped hole in the map answers with an error and no data
    bus_rd(9'h118, d, r);
    chk_resp(r, RESP_ER);
    chk_data(d, ZERO32);
    bus_wr(9'h118, seed, r);
    chk_resp(r, RESP_ER);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
